// File: rtl/fsk_modem_ctl.sv
// send grant, carrier qualification and tone selection for a 300 bps fsk modem
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "fsk_consts.svh"

module fsk_modem_ctl #(
  parameter int TICK_CYC = `FSK_TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic request_to_send_in_n,
  input wire logic delay_select_low,
  input wire logic delay_select_high,
  input wire logic carrier_detect_fast_n,
  input wire logic send_grant_ext_n,
  input wire logic answer_originate,
  input wire logic transmit_data_in,
  input wire logic demod_data_in,
  input wire logic carrier_detect_qualified_in_n,
  output logic carrier_detect_qualified_out_n,
  output logic carrier_detect_qualified_oe,
  output logic clear_to_send_n,
  output logic received_data,
  output logic transmit_active,
  output logic [11:0] tone_freq_hz,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // built-in delay for one kind of timer; reserved codes fall back to 00
  function automatic logic [15:0] delay_ticks(input fsk_pkg::fsk_dly_t kind,
                                              input logic na, input logic [1:0] sel);
    logic [15:0] t;
    t = 16'h0000;
    case (kind)
      fsk_pkg::FSK_DLY_GRANT: begin
        if (na) t = `FSK_TICKS(`FSK_GRANT_NA_US);
        else if (sel == 2'h1) t = `FSK_TICKS(`FSK_GRANT_V21_01_US);
        else if (sel == 2'h2) t = `FSK_TICKS(`FSK_GRANT_V21_10_US);
        else t = `FSK_TICKS(`FSK_GRANT_V21_00_US);
      end
      fsk_pkg::FSK_DLY_CDON: begin
        if (na) t = `FSK_TICKS(`FSK_CDON_NA_US);
        else if (sel == 2'h1) t = `FSK_TICKS(`FSK_CDON_V21_01_US);
        else if (sel == 2'h2) t = `FSK_TICKS(`FSK_CDON_V21_10_US);
        else t = `FSK_TICKS(`FSK_CDON_V21_00_US);
      end
      default: begin
        if (na) t = `FSK_TICKS(`FSK_CDOFF_NA_US);
        else if (sel == 2'h2) t = `FSK_TICKS(`FSK_CDOFF_V21_10_US);
        else t = `FSK_TICKS(`FSK_CDOFF_V21_0X_US);
      end
    endcase
    return t;
  endfunction : delay_ticks

  // tone for variant, mode and data bit
  function automatic logic [11:0] tone_of(input logic na, input logic org, input logic mark);
    logic [11:0] f;
    f = 12'h000;
    case ({na, org, mark})
      3'b011: f = `FSK_V21_ORG_MARK;
      3'b010: f = `FSK_V21_ORG_SPACE;
      3'b001: f = `FSK_V21_ANS_MARK;
      3'b000: f = `FSK_V21_ANS_SPACE;
      3'b111: f = `FSK_NA_ORG_MARK;
      3'b110: f = `FSK_NA_ORG_SPACE;
      3'b101: f = `FSK_NA_ANS_MARK;
      default: f = `FSK_NA_ANS_SPACE;
    endcase
    return f;
  endfunction : tone_of

  fsk_pkg::fsk_pins_t pin_raw;
  fsk_pkg::fsk_pins_t pin_meta_ff;
  fsk_pkg::fsk_pins_t pin_ff;
  fsk_pkg::fsk_cts_st_t cts_st_ff;
  logic [15:0] tick_cnt_ff;
  logic tick;
  logic [15:0] grant_cnt_ff;
  logic [15:0] softoff_cnt_ff;
  logic [15:0] cd_cnt_ff;
  logic cd_on_ff;
  logic variant_na_ff;
  logic ext_mode;
  logic [1:0] sel;
  logic [15:0] grant_target;
  logic [15:0] cdon_target;
  logic [15:0] cdoff_target;
  logic grant_done;

  assign pin_raw = '{rts_n: request_to_send_in_n, sel_low: delay_select_low,
                     sel_high: delay_select_high, cd_fast_n: carrier_detect_fast_n,
                     cd_ext_n: carrier_detect_qualified_in_n, grant_ext_n: send_grant_ext_n,
                     originate: answer_originate, txd: transmit_data_in,
                     rxd: demod_data_in};

  // two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge aclk) begin
    pin_meta_ff <= pin_raw;
    pin_ff <= pin_meta_ff;
  end

  assign sel = {pin_ff.sel_high, pin_ff.sel_low};
  assign ext_mode = pin_ff.sel_high & pin_ff.sel_low;
  assign grant_target = delay_ticks(fsk_pkg::FSK_DLY_GRANT, variant_na_ff, sel);
  assign cdon_target = delay_ticks(fsk_pkg::FSK_DLY_CDON, variant_na_ff, sel);
  assign cdoff_target = delay_ticks(fsk_pkg::FSK_DLY_CDOFF, variant_na_ff, sel);

  // shared timer tick; one divider keeps every delay a fixed terminal count
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) tick_cnt_ff <= 16'h0000;
    else tick_cnt_ff <= tick_cnt_ff + 16'h0001;
  end
  assign tick = (tick_cnt_ff == 16'(TICK_CYC - 1));

  // outside timer wins in external mode, else the built-in count
  assign grant_done = ext_mode ? !pin_ff.grant_ext_n : (grant_cnt_ff >= grant_target);

  // send grant sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_st_ff <= fsk_pkg::FSK_CTS_IDLE;
      grant_cnt_ff <= 16'h0000;
    end else if (pin_ff.rts_n) begin
      cts_st_ff <= fsk_pkg::FSK_CTS_IDLE;
      grant_cnt_ff <= 16'h0000;
    end else begin
      case (cts_st_ff)
        fsk_pkg::FSK_CTS_IDLE: begin
          cts_st_ff <= fsk_pkg::FSK_CTS_WAIT;
          grant_cnt_ff <= 16'h0000;
        end
        fsk_pkg::FSK_CTS_WAIT: begin
          if (grant_done) cts_st_ff <= fsk_pkg::FSK_CTS_ON;
          else if (tick) grant_cnt_ff <= grant_cnt_ff + 16'h0001;
        end
        fsk_pkg::FSK_CTS_ON: cts_st_ff <= fsk_pkg::FSK_CTS_ON;
        default: cts_st_ff <= fsk_pkg::FSK_CTS_IDLE;
      endcase
    end
  end
  assign clear_to_send_n = (cts_st_ff != fsk_pkg::FSK_CTS_ON);

  // soft turn-off keeps the carrier fading after request release; reset parks the count
  // at its end, so no fade follows power-up without a request ever made
  always_ff @(posedge aclk) begin
    if (!aresetn) softoff_cnt_ff <= `FSK_TICKS(`FSK_SOFTOFF_US);
    else if (!pin_ff.rts_n) softoff_cnt_ff <= 16'h0000;
    else if (transmit_active && tick) softoff_cnt_ff <= softoff_cnt_ff + 16'h0001;
  end
  assign transmit_active = aresetn &&
                           (!pin_ff.rts_n || softoff_cnt_ff < `FSK_TICKS(`FSK_SOFTOFF_US));

  // carrier qualification: outside external mode the fast detector must hold for the whole delay; external mode copies the outside timer pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cd_on_ff <= 1'b0;
      cd_cnt_ff <= 16'h0000;
    end else if (ext_mode) begin
      cd_on_ff <= !pin_ff.cd_ext_n;
      cd_cnt_ff <= 16'h0000;
    end else if (cd_on_ff == !pin_ff.cd_fast_n) begin
      cd_cnt_ff <= 16'h0000; // glitch restarts the count
    end else if (!cd_on_ff && cd_cnt_ff >= cdon_target) begin
      cd_on_ff <= 1'b1;
      cd_cnt_ff <= 16'h0000;
    end else if (cd_on_ff && cd_cnt_ff >= cdoff_target) begin
      cd_on_ff <= 1'b0;
      cd_cnt_ff <= 16'h0000;
    end else if (tick) begin
      cd_cnt_ff <= cd_cnt_ff + 16'h0001;
    end
  end
  assign carrier_detect_qualified_oe = !ext_mode;
  assign carrier_detect_qualified_out_n = !cd_on_ff;
  assign received_data = cd_on_ff ? pin_ff.rxd : 1'b1;

  // tone register; high mode pin means originate
  always_ff @(posedge aclk) begin
    if (!aresetn) tone_freq_hz <= `FSK_V21_ANS_MARK;
    else tone_freq_hz <= tone_of(variant_na_ff, pin_ff.originate, pin_ff.txd);
  end

  // axi4-lite write: address and data taken together, one write at a time
  logic wr_take;
  logic wr_hit;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_take = s_axi_awready;
  assign wr_hit = (s_axi_awaddr == `FSK_CTRL_OFS) || (s_axi_awaddr == `FSK_STATUS_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      variant_na_ff <= `FSK_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FSK_RESP_OKAY;
    end else begin
      if (wr_take && s_axi_awaddr == `FSK_CTRL_OFS && s_axi_wstrb[0])
        variant_na_ff <= s_axi_wdata[`FSK_CTRL_VARIANT_BIT];
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `FSK_RESP_OKAY : `FSK_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read; status is sampled at the address handshake
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FSK_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FSK_RESP_OKAY;
      if (s_axi_araddr == `FSK_CTRL_OFS) s_axi_rdata <= {31'h00000000, variant_na_ff};
      else if (s_axi_araddr == `FSK_STATUS_OFS)
        s_axi_rdata <= {15'h0000, tone_freq_hz, ext_mode, transmit_active, cd_on_ff,
                        !clear_to_send_n, received_data};
      else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `FSK_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks sleep through reset; the synced pins are unknown until the flops flush
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence req_release_s;
    !$past(pin_ff.rts_n) && pin_ff.rts_n;
  endsequence
  sequence grant_low_s;
    $fell(clear_to_send_n);
  endsequence

  grant_needs_delay_a: assert property (grant_low_s |-> $past(grant_done && !pin_ff.rts_n))
    else $error("clear to send fell before the delay expired");
  grant_drop_fast_a: assert property (req_release_s |=> clear_to_send_n)
    else $error("clear to send still low after request release");
  softoff_hold_a: assert property (req_release_s |-> transmit_active [*8])
    else $error("transmitter stopped without soft turn-off");
  grant_count_a: assert property ((grant_low_s and !$past(ext_mode))
                                  |-> $past(grant_cnt_ff) >= $past(grant_target))
    else $error("built-in grant delay cut short");
  cd_on_count_a: assert property ($rose(cd_on_ff) && !$past(ext_mode)
                                  |-> $past(cd_cnt_ff) >= $past(cdon_target))
    else $error("carrier reported before qualification");
  cd_off_count_a: assert property ($fell(cd_on_ff) && !$past(ext_mode)
                                   |-> $past(cd_cnt_ff) >= $past(cdoff_target))
    else $error("carrier withdrawn before off delay");
  rx_mark_a: assert property (!cd_on_ff |-> received_data)
    else $error("received data not mark while carrier off");
  ext_pin_in_a: assert property (ext_mode |-> !carrier_detect_qualified_oe
                                 ##1 (cd_on_ff == !$past(pin_ff.cd_ext_n)))
    else $error("qualified carrier pin not following outside timer");
  tone_mode_a: assert property (##1 $past(variant_na_ff) == 1'b0 && $past(pin_ff.originate)
                                && $past(pin_ff.txd) |-> tone_freq_hz == `FSK_V21_ORG_MARK)
    else $error("wrong originate mark tone");
  tone_na_a: assert property (##1 $past(variant_na_ff) && !$past(pin_ff.originate)
                              && !$past(pin_ff.txd) |-> tone_freq_hz == `FSK_NA_ANS_SPACE)
    else $error("wrong answer space tone");
  tick_period_a: assert property (tick |=> !tick)
    else $error("timer tick wider than one cycle");

endmodule : fsk_modem_ctl

// File: include/fsk_consts.svh
// timing counts, tone frequencies and register offsets of the fsk control block
`ifndef FSK_CONSTS_SVH
`define FSK_CONSTS_SVH

// clock and timer tick
`define FSK_CLK_NS 100
`define FSK_TICK_US 100
`define FSK_TICK_CYC ((`FSK_TICK_US * 1000) / `FSK_CLK_NS)

// send grant delays in microseconds, mid of the window
`define FSK_GRANT_V21_00_US 400000
`define FSK_GRANT_V21_01_US 30000
`define FSK_GRANT_V21_10_US 350000
`define FSK_GRANT_NA_US 200000
// carrier on qualification, mid of each window
`define FSK_CDON_V21_00_US 310000
`define FSK_CDON_V21_01_US 12500
`define FSK_CDON_V21_10_US 160000
`define FSK_CDON_NA_US 110000
// carrier off qualification, mid of each window
`define FSK_CDOFF_V21_0X_US 45000
`define FSK_CDOFF_V21_10_US 25000
`define FSK_CDOFF_NA_US 30000
// transmitter soft turn-off
`define FSK_SOFTOFF_US 10000
`define FSK_TICKS(us) (16'((us) / `FSK_TICK_US))

// tones in hertz
`define FSK_V21_ORG_MARK 12'h3D4
`define FSK_V21_ORG_SPACE 12'h49C
`define FSK_V21_ANS_MARK 12'h672
`define FSK_V21_ANS_SPACE 12'h73A
`define FSK_NA_ORG_MARK 12'h4F6
`define FSK_NA_ORG_SPACE 12'h42E
`define FSK_NA_ANS_MARK 12'h8B1
`define FSK_NA_ANS_SPACE 12'h7E9

// register map
`define FSK_CTRL_OFS 8'h00
`define FSK_STATUS_OFS 8'h04
`define FSK_CTRL_VARIANT_BIT 0
`define FSK_CTRL_RESET 1'b0
`define FSK_RESP_OKAY 2'h0
`define FSK_RESP_SLVERR 2'h2

`endif

// File: include/fsk_pkg.sv
// types shared by the fsk control block
package fsk_pkg;

  typedef enum {FSK_CTS_IDLE, FSK_CTS_WAIT, FSK_CTS_ON} fsk_cts_st_t;

  typedef enum logic [1:0] {FSK_DLY_GRANT, FSK_DLY_CDON, FSK_DLY_CDOFF} fsk_dly_t;

  // pin inputs, all from outside the clock domain
  typedef struct packed {
    logic rts_n;
    logic sel_low;
    logic sel_high;
    logic cd_fast_n;
    logic cd_ext_n;
    logic grant_ext_n;
    logic originate;
    logic txd;
    logic rxd;
  } fsk_pins_t;

endpackage : fsk_pkg

// File: verification/fsk_dte_model.sv
// terminal side model: request line plus the outside delay timers
`timescale 1ns/1ns
module fsk_dte_model #(
  parameter int GRANT_CYC = 300,
  parameter int CD_CYC = 150
) (
  input wire logic aclk,
  input wire logic req,
  input wire logic cd_fast_n,
  output logic rts_n,
  output logic grant_n,
  output logic cd_ext_n
);
  int gcnt;
  int ccnt;
  // idle terminal: no request, timers released
  initial begin
    rts_n = 1'b1;
    grant_n = 1'b1;
    cd_ext_n = 1'b1;
    gcnt = 0;
    ccnt = 0;
  end
  // request held low for the whole send
  always @(posedge aclk) begin
    rts_n <= ~req;
  end
  // outside grant timer restarts on release, so a short request never grants
  always @(posedge aclk) begin
    gcnt <= rts_n ? 0 : (gcnt < GRANT_CYC ? gcnt + 1 : gcnt);
    grant_n <= rts_n | (gcnt < GRANT_CYC);
  end
  // outside carrier timer: any bounce restarts the count
  always @(posedge aclk) begin
    if (cd_fast_n == cd_ext_n) begin
      ccnt <= 0;
    end else if (ccnt == CD_CYC) begin
      cd_ext_n <= cd_fast_n;
      ccnt <= 0;
    end else begin
      ccnt <= ccnt + 1;
    end
  end
endmodule : fsk_dte_model

// File: verification/test_fsk_modem_control_timing.sv
// self-checking bench for the fsk modem control block
`timescale 1ns/1ns
`include "fsk_consts.svh"
module test_fsk_modem_control_timing;
  localparam int T = 2;
  localparam logic [11:0] TONE [8] = '{`FSK_V21_ANS_SPACE, `FSK_V21_ANS_MARK, `FSK_V21_ORG_SPACE,
    `FSK_V21_ORG_MARK, `FSK_NA_ANS_SPACE, `FSK_NA_ANS_MARK, `FSK_NA_ORG_SPACE, `FSK_NA_ORG_MARK};
  logic aclk = 1'b0, aresetn = 1'b0, req = 1'b0, sel_l = 1'b0, sel_h = 1'b0, cd_fast_n = 1'b1;
  logic demod = 1'b0, mode = 1'b0, txd = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, rts_n, grant_n, cd_ext_n, cd_out_n, cd_oe, cts_n, rxd;
  logic tx_act, cd_pin, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [11:0] tone;
  int failures = 0, check_count = 0;
  // shared carrier pin: device drives unless outside timers own it
  assign cd_pin = cd_oe ? cd_out_n : cd_ext_n;
  fsk_modem_ctl #(.TICK_CYC(T)) i_fsk_modem_ctl (.aclk(aclk), .aresetn(aresetn),
    .request_to_send_in_n(rts_n), .delay_select_low(sel_l), .delay_select_high(sel_h),
    .carrier_detect_fast_n(cd_fast_n), .send_grant_ext_n(grant_n), .answer_originate(mode),
    .transmit_data_in(txd), .demod_data_in(demod), .carrier_detect_qualified_in_n(cd_pin),
    .carrier_detect_qualified_out_n(cd_out_n), .carrier_detect_qualified_oe(cd_oe),
    .clear_to_send_n(cts_n), .received_data(rxd), .transmit_active(tx_act), .tone_freq_hz(tone),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  fsk_dte_model #(.GRANT_CYC(300), .CD_CYC(150)) i_fsk_dte_model (.aclk(aclk), .req(req),
    .cd_fast_n(cd_fast_n), .rts_n(rts_n), .grant_n(grant_n), .cd_ext_n(cd_ext_n));
  // 10 MHz clock
  initial begin
    forever #50 aclk = ~aclk;
  end
  task test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  function logic sg(input int s);
    case (s)
      0: return cts_n;
      1: return cd_out_n;
      2: return tx_act;
      default: return rxd;
    endcase
  endfunction : sg
  // counts falling edges until the watched output reaches lvl; bounded
  task wt(input int s, input logic lvl, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(negedge aclk);
      if (sg(s) === lvl) return;
    end
    tmo;
  endtask : wt
  // a wait that runs out counts as a mismatch and ends the run
  task tmo;
    failures++;
    $display("ERROR %0t: wait ran out", $time);
    test_done;
  endtask : tmo
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && !(awready === 1'b1 && wready === 1'b1); i++) @(negedge aclk);
    if (i == 50) tmo;
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    for (i = 0; i < 50 && bvalid !== 1'b1; i++) @(negedge aclk);
    if (i == 50) tmo;
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && arready !== 1'b1; i++) @(negedge aclk);
    if (i == 50) tmo;
    @(posedge aclk);
    arvalid <= 1'b0;
    for (i = 0; i < 50 && rvalid !== 1'b1; i++) @(negedge aclk);
    if (i == 50) tmo;
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_rd
  // pins pass a two-flop sync, so give them a few edges to land
  task setcode(input logic [1:0] c);
    @(posedge aclk);
    {sel_h, sel_l} <= c;
    repeat (4) @(posedge aclk);
  endtask : setcode
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    chk({cts_n, cd_out_n, rxd, tx_act}, 4'hE);
    chk(tone, `FSK_V21_ANS_MARK);
    axi_rd(`FSK_CTRL_OFS, d, r);
    chk(d, 32'h0);
    chk(r, `FSK_RESP_OKAY);
    axi_wr(`FSK_STATUS_OFS, 32'hFFFFFFFF, r);
    chk(r, `FSK_RESP_OKAY);
    axi_wr(8'h08, 32'h1, r);
    chk(r, `FSK_RESP_SLVERR);
    axi_rd(8'h08, d, r);
    chk(d, 32'h0);
    chk(r, `FSK_RESP_SLVERR);
    $display("register test done");
  endtask : t_regs
  task grant_case(input logic [1:0] c, input int tk);
    int n;
    setcode(c);
    req <= 1'b1;
    wt(0, 1'b0, tk * T + 40, n);
    chk(n >= tk * T - T && n <= tk * T + 16, 1);
    chk(tx_act, 1'b1);
    @(posedge aclk);
    req <= 1'b0;
    wt(0, 1'b1, 50, n);
    chk(n <= 5, 1);
    wt(2, 1'b0, 300, n);
    chk(n >= 100 * T - 8 && n <= 100 * T + 16, 1);
    $display("grant test code %0b done", c);
  endtask : grant_case
  task cd_case(input logic [1:0] c, input int on_tk, input int off_tk);
    int n;
    setcode(c);
    chk({cd_oe, rxd}, 2'h3);
    cd_fast_n <= 1'b0;
    wt(1, 1'b0, on_tk * T + 40, n);
    chk(n >= on_tk * T - T && n <= on_tk * T + 16, 1);
    chk(rxd, demod);
    @(posedge aclk);
    cd_fast_n <= 1'b1;
    wt(1, 1'b1, off_tk * T + 40, n);
    chk(n >= off_tk * T - T && n <= off_tk * T + 16, 1);
    chk(rxd, 1'b1);
    $display("carrier test code %0b done", c);
  endtask : cd_case
  task t_tones;
    logic [1:0] r;
    logic [31:0] d;
    for (int v = 0; v < 2; v++) begin
      axi_wr(`FSK_CTRL_OFS, 32'(v), r);
      chk(r, `FSK_RESP_OKAY);
      axi_rd(`FSK_CTRL_OFS, d, r);
      chk(d, 32'(v));
      for (int j = 0; j < 4; j++) begin
        @(posedge aclk);
        {mode, txd} <= 2'(j);
        repeat (6) @(negedge aclk);
        chk(tone, TONE[v * 4 + j]);
      end
    end
    $display("tone test done");
  endtask : t_tones
  task t_ext;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    setcode(2'b11);
    chk(cd_oe, 1'b0);
    req <= 1'b1;
    cd_fast_n <= 1'b0;
    wt(3, 1'b0, 400, n);
    chk(n >= 150 && n <= 170, 1);
    wt(0, 1'b0, 400, n);
    chk(n >= 130 && n <= 170, 1);
    axi_rd(`FSK_STATUS_OFS, d, r);
    chk(d[16:0], {`FSK_NA_ORG_MARK, 5'h1E});
    @(posedge aclk);
    req <= 1'b0;
    cd_fast_n <= 1'b1;
    wt(3, 1'b1, 400, n);
    chk(n >= 150 && n <= 170, 1);
    $display("outside timer test done");
  endtask : t_ext
  // main sequence: reset, then every scenario in turn
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_regs;
    grant_case(2'b00, 4000);
    grant_case(2'b01, 300);
    grant_case(2'b10, 3500);
    cd_case(2'b00, 3100, 450);
    cd_case(2'b01, 125, 450);
    cd_case(2'b10, 1600, 250);
    t_tones;
    grant_case(2'b00, 2000);
    cd_case(2'b00, 1100, 300);
    t_ext;
    test_done;
  end
endmodule : test_fsk_modem_control_timing
